// ===== hdl/aftd_chan_detect.sv
// one channel of magnitude detection with hysteresis and dwell
`timescale 1ns/100ps
module aftd_chan_detect (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [aftd_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic [aftd_pkg::MAG_W-1:0] upper_i,
  input wire logic [aftd_pkg::MAG_W-1:0] lower_i,
  input wire logic [aftd_pkg::DWELL_W-1:0] dwell_i,
  output logic threshold_flag_o
);
  logic [aftd_pkg::SAMPLE_W-1:0] abs_full;
  logic [aftd_pkg::MAG_W-1:0] mag;
  logic [aftd_pkg::DWELL_W-1:0] below_cnt;
  logic [aftd_pkg::DWELL_W-1:0] dwell_eff;
  logic above;
  logic below;

  ////////////////////////////////////////////////////////////////////////////
  // RULE15 absolute magnitude
  always_comb begin
    abs_full = sample_i[aftd_pkg::SAMPLE_W-1] ? (~sample_i + 1'b1) : sample_i;
  end

  // most negative code has no 13-bit magnitude, so it saturates
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      mag <= '0;
    end else if (abs_full[aftd_pkg::MAG_W]) begin
      mag <= aftd_pkg::MAG_FULL;
    end else begin
      mag <= abs_full[aftd_pkg::MAG_W-1:0];
    end
  end

  // RULE7 zero dwell acts as minimum
  assign dwell_eff = (dwell_i < aftd_pkg::DWELL_MIN) ? aftd_pkg::DWELL_MIN : dwell_i;
  // RULE4 compare at output
  // RULE6 full-resolution compares
  assign above = mag > upper_i;
  assign below = mag < lower_i;

  ////////////////////////////////////////////////////////////////////////////
  // RULE14 restart dwell count
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      below_cnt <= '0;
    end else if (above || !below || below_cnt >= dwell_eff) begin
      below_cnt <= '0;
    end else begin
      below_cnt <= below_cnt + 1'b1;
    end
  end

  // RULE2 set immediately
  // RULE3 clear after dwell
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      threshold_flag_o <= 1'b0;
    end else if (above) begin
      threshold_flag_o <= 1'b1;
    end else if (below && below_cnt >= dwell_eff) begin
      threshold_flag_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_exceed;
    (abs_full > aftd_pkg::SAMPLE_W'(upper_i)) && $stable(upper_i);
  endsequence
  property p_flag_rise;
    s_exceed ##1 $stable(upper_i) |=> threshold_flag_o;
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag not raised two cycles after exceed"); // RULE4

  property p_hold_not_below;
    threshold_flag_o && !below |=> threshold_flag_o;
  endproperty
  a_hold_not_below: assert property (p_hold_not_below) else $error("flag cleared without low magnitude"); // RULE3

  sequence s_dwell_done;
    !above && below && below_cnt == dwell_eff;
  endsequence
  property p_clear_after_dwell;
    s_dwell_done |=> !threshold_flag_o && below_cnt == '0;
  endproperty
  a_clear_after_dwell: assert property (p_clear_after_dwell) else $error("flag not cleared after dwell"); // RULE3

  property p_restart;
    !below |=> below_cnt == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("dwell count not restarted"); // RULE14

  property p_saturate;
    sample_i == aftd_pkg::MOST_NEG |=> mag == aftd_pkg::MAG_FULL;
  endproperty
  a_saturate: assert property (p_saturate) else $error("most negative code not saturated"); // RULE15
endmodule : aftd_chan_detect

// ===== hdl/aftd_ovr_sticky.sv
// sticky overrange status per virtual converter with toggle clear
`timescale 1ns/100ps
module aftd_ovr_sticky (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [aftd_pkg::NUM_VC-1:0] vc_overrange_i,
  input wire logic [aftd_pkg::NUM_VC-1:0] clear_i,
  output logic [aftd_pkg::NUM_VC-1:0] status_o
);
  logic [aftd_pkg::NUM_VC-1:0] clear_q;
  logic [aftd_pkg::NUM_VC-1:0] clear_fall;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      clear_q <= '0;
    end else begin
      clear_q <= clear_i;
    end
  end

  // RULE13 high then low clears
  assign clear_fall = clear_q & ~clear_i;

  for (genvar v = 0; v < aftd_pkg::NUM_VC; v++) begin : g_vc
    // RULE12 latch each converter; a new event wins over the clear
    always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
        status_o[v] <= 1'b0;
      end else if (vc_overrange_i[v]) begin
        status_o[v] <= 1'b1;
      end else if (clear_fall[v]) begin
        status_o[v] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_set;
    vc_overrange_i != '0 |=> (status_o & $past(vc_overrange_i)) == $past(vc_overrange_i);
  endproperty
  a_set: assert property (p_set) else $error("overrange event not latched"); // RULE12

  sequence s_toggle;
    (clear_i != '0) ##1 ((clear_q & ~clear_i) != '0);
  endsequence
  property p_clear;
    s_toggle |=> (status_o & $past(clear_fall) & ~$past(vc_overrange_i)) == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("sticky bit not cleared on toggle"); // RULE13
endmodule : aftd_ovr_sticky

// ===== hdl/aftd_pkg.sv
// shared constants for the fast threshold detect block
package aftd_pkg;
  localparam int SAMPLE_W = 14;
  localparam int MAG_W = 13;
  localparam int DWELL_W = 16;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 15;
  localparam int NUM_CH = 2;
  localparam int NUM_VC = 8;
  localparam int CSPS_W = 2;
  localparam int LINK_W = 16;
  localparam int OVR_BIT = 1;
  localparam int SHIFT_W = 24;
  localparam int CNT_W = 5;
  // worst-case flag latency allowed; this design needs two cycles
  localparam int FLAG_MAX_LAT = 28;
  localparam logic [CNT_W-1:0] CNT_INSTR = 5'h10;
  localparam logic [CNT_W-1:0] CNT_FRAME = 5'h18;
  localparam logic [ADDR_W-1:0] ADDR_UPPER_LO = 15'h0247;
  localparam logic [ADDR_W-1:0] ADDR_UPPER_HI = 15'h0248;
  localparam logic [ADDR_W-1:0] ADDR_LOWER_LO = 15'h0249;
  localparam logic [ADDR_W-1:0] ADDR_LOWER_HI = 15'h024a;
  localparam logic [ADDR_W-1:0] ADDR_DWELL_LO = 15'h024b;
  localparam logic [ADDR_W-1:0] ADDR_DWELL_HI = 15'h024c;
  localparam logic [ADDR_W-1:0] ADDR_OVR_CLEAR = 15'h0562;
  localparam logic [ADDR_W-1:0] ADDR_OVR_STATUS = 15'h0563;
  localparam logic [MAG_W-1:0] UPPER_RST = 13'h1fff;
  localparam logic [MAG_W-1:0] LOWER_RST = 13'h0000;
  localparam logic [DWELL_W-1:0] DWELL_RST = 16'h0001;
  localparam logic [DWELL_W-1:0] DWELL_MIN = 16'h0001;
  localparam logic [MAG_W-1:0] MAG_FULL = 13'h1fff;
  localparam logic [SAMPLE_W-1:0] MOST_NEG = 14'h2000;
  localparam logic [DATA_W-1:0] CLEAR_RST = 8'h00;
endpackage : aftd_pkg

// ===== hdl/aftd_top.sv
// fast threshold detect, overrange link bit and serial register port
`timescale 1ns/100ps
// Behaviour
// RULE1: separate detect circuit and pin per channel
// RULE2: flag rises at once above upper threshold
// RULE3: flag drops after dwell below lower threshold
// RULE4: upper compare at output, within 28 cycles
// RULE5: thresholds scaled to 8192 full scale
// RULE6: 13-bit lower threshold, full-resolution compare
// RULE7: dwell count 1 to 65535 cycles
// RULE8: upper threshold in byte pair 0x0247
// RULE9: lower pair 0x0249, dwell pair 0x024b
// RULE10: overrange bit aligned with its sample
// RULE11: overrange carried as link control bit
// RULE12: sticky overrange per virtual converter at 0x0563
// RULE13: clear overrange_clear toggled high then low
// RULE14: reset flags, restart dwell above lower
// RULE15: magnitude is 13-bit absolute sample value
module aftd_top (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [aftd_pkg::SAMPLE_W-1:0] sample_ch0_i,
  input wire logic [aftd_pkg::SAMPLE_W-1:0] sample_ch1_i,
  input wire logic overrange_ch0_i,
  input wire logic overrange_ch1_i,
  input wire logic [aftd_pkg::NUM_VC-1:0] vc_overrange_i,
  input wire logic [aftd_pkg::CSPS_W-1:0] control_bits_per_sample_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_n_o,
  output logic threshold_flag_pin_ch0_o,
  output logic threshold_flag_pin_ch1_o,
  output logic [aftd_pkg::LINK_W-1:0] link_sample_ch0_o,
  output logic [aftd_pkg::LINK_W-1:0] link_sample_ch1_o
);
  logic [aftd_pkg::MAG_W-1:0] upper_thr;
  logic [aftd_pkg::MAG_W-1:0] lower_thr;
  logic [aftd_pkg::DWELL_W-1:0] dwell;
  logic [aftd_pkg::DATA_W-1:0] ovr_clear;
  logic [aftd_pkg::NUM_VC-1:0] ovr_status;

  logic sclk_q;
  logic sclk_rise;
  logic sclk_fall;
  logic [aftd_pkg::CNT_W-1:0] bit_cnt;
  logic [aftd_pkg::SHIFT_W-1:0] shreg;
  logic [aftd_pkg::SHIFT_W-1:0] next_shreg;
  logic [aftd_pkg::ADDR_W:0] instr;
  logic [aftd_pkg::DATA_W-1:0] sdo_shift;
  logic reading;
  logic instr_done;
  logic wr_stb;
  logic [aftd_pkg::ADDR_W-1:0] wr_addr;
  logic [aftd_pkg::DATA_W-1:0] wr_data;
  logic [aftd_pkg::ADDR_W-1:0] rd_addr;
  logic [aftd_pkg::DATA_W-1:0] rd_data;

  logic [aftd_pkg::SAMPLE_W-1:0] sample_arr [aftd_pkg::NUM_CH];
  logic ovr_arr [aftd_pkg::NUM_CH];
  logic flag_arr [aftd_pkg::NUM_CH];
  logic [aftd_pkg::LINK_W-1:0] link_arr [aftd_pkg::NUM_CH];
  logic ctrl_en;

  ////////////////////////////////////////////////////////////////////////////
  // serial port: 16-bit instruction (read flag, 15-bit address), one data byte
  // sclk is sampled as an ordinary input, so it must run well below core_clk
  assign sclk_rise = spi_sclk_i && !sclk_q;
  assign sclk_fall = !spi_sclk_i && sclk_q;
  assign next_shreg = {shreg[aftd_pkg::SHIFT_W-2:0], spi_sdi_i};
  assign instr_done = sclk_rise && !spi_cs_n_i && bit_cnt == aftd_pkg::CNT_INSTR - 1'b1;
  assign wr_stb = sclk_rise && !spi_cs_n_i && bit_cnt == aftd_pkg::CNT_FRAME - 1'b1 &&
                  !instr[aftd_pkg::ADDR_W];
  assign wr_addr = instr[aftd_pkg::ADDR_W-1:0];
  assign wr_data = next_shreg[aftd_pkg::DATA_W-1:0];
  assign rd_addr = next_shreg[aftd_pkg::ADDR_W-1:0];

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= spi_sclk_i;
    end
  end

  // extra clocks past one frame are ignored until chip select rises
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || spi_cs_n_i) begin
      bit_cnt <= '0;
      shreg <= '0;
    end else if (sclk_rise && bit_cnt < aftd_pkg::CNT_FRAME) begin
      bit_cnt <= bit_cnt + 1'b1;
      shreg <= next_shreg;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      instr <= '0;
    end else if (instr_done) begin
      instr <= next_shreg[aftd_pkg::ADDR_W:0];
    end
  end

  // read data is loaded at the last instruction edge and shifted on falling edges
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || spi_cs_n_i) begin
      sdo_shift <= '0;
      reading <= 1'b0;
    end else if (instr_done && next_shreg[aftd_pkg::ADDR_W]) begin
      sdo_shift <= rd_data;
      reading <= 1'b1;
    end else if (sclk_fall && bit_cnt > aftd_pkg::CNT_INSTR) begin
      sdo_shift <= {sdo_shift[aftd_pkg::DATA_W-2:0], 1'b0};
    end
  end

  assign spi_sdo_o = sdo_shift[aftd_pkg::DATA_W-1];
  assign spi_sdo_oe_n_o = !reading;

  ////////////////////////////////////////////////////////////////////////////
  // RULE8 upper threshold pair
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      upper_thr <= aftd_pkg::UPPER_RST;
    end else if (wr_stb && wr_addr == aftd_pkg::ADDR_UPPER_LO) begin
      upper_thr[aftd_pkg::DATA_W-1:0] <= wr_data;
    end else if (wr_stb && wr_addr == aftd_pkg::ADDR_UPPER_HI) begin
      upper_thr[aftd_pkg::MAG_W-1:aftd_pkg::DATA_W] <= wr_data[aftd_pkg::MAG_W-aftd_pkg::DATA_W-1:0];
    end
  end

  // RULE9 lower threshold pair
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      lower_thr <= aftd_pkg::LOWER_RST;
    end else if (wr_stb && wr_addr == aftd_pkg::ADDR_LOWER_LO) begin
      lower_thr[aftd_pkg::DATA_W-1:0] <= wr_data;
    end else if (wr_stb && wr_addr == aftd_pkg::ADDR_LOWER_HI) begin
      lower_thr[aftd_pkg::MAG_W-1:aftd_pkg::DATA_W] <= wr_data[aftd_pkg::MAG_W-aftd_pkg::DATA_W-1:0];
    end
  end

  // RULE9 dwell count pair
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      dwell <= aftd_pkg::DWELL_RST;
    end else if (wr_stb && wr_addr == aftd_pkg::ADDR_DWELL_LO) begin
      dwell[aftd_pkg::DATA_W-1:0] <= wr_data;
    end else if (wr_stb && wr_addr == aftd_pkg::ADDR_DWELL_HI) begin
      dwell[aftd_pkg::DWELL_W-1:aftd_pkg::DATA_W] <= wr_data;
    end
  end

  // RULE13 clear register
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ovr_clear <= aftd_pkg::CLEAR_RST;
    end else if (wr_stb && wr_addr == aftd_pkg::ADDR_OVR_CLEAR) begin
      ovr_clear <= wr_data;
    end
  end

  // unmapped addresses read as zero
  always_comb begin
    rd_data = '0;
    case (rd_addr)
      aftd_pkg::ADDR_UPPER_LO: rd_data = upper_thr[aftd_pkg::DATA_W-1:0];
      aftd_pkg::ADDR_UPPER_HI: rd_data[aftd_pkg::MAG_W-aftd_pkg::DATA_W-1:0] =
                                 upper_thr[aftd_pkg::MAG_W-1:aftd_pkg::DATA_W];
      aftd_pkg::ADDR_LOWER_LO: rd_data = lower_thr[aftd_pkg::DATA_W-1:0];
      aftd_pkg::ADDR_LOWER_HI: rd_data[aftd_pkg::MAG_W-aftd_pkg::DATA_W-1:0] =
                                 lower_thr[aftd_pkg::MAG_W-1:aftd_pkg::DATA_W];
      aftd_pkg::ADDR_DWELL_LO: rd_data = dwell[aftd_pkg::DATA_W-1:0];
      aftd_pkg::ADDR_DWELL_HI: rd_data = dwell[aftd_pkg::DWELL_W-1:aftd_pkg::DATA_W];
      aftd_pkg::ADDR_OVR_CLEAR: rd_data = ovr_clear;
      aftd_pkg::ADDR_OVR_STATUS: rd_data = ovr_status;
      default: rd_data = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE12 sticky status
  aftd_ovr_sticky u_sticky (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .vc_overrange_i(vc_overrange_i),
    .clear_i(ovr_clear),
    .status_o(ovr_status)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign sample_arr[0] = sample_ch0_i;
  assign sample_arr[1] = sample_ch1_i;
  assign ovr_arr[0] = overrange_ch0_i;
  assign ovr_arr[1] = overrange_ch1_i;
  assign ctrl_en = control_bits_per_sample_i != '0;

  for (genvar c = 0; c < aftd_pkg::NUM_CH; c++) begin : g_ch
    // RULE1 independent detector
    // RULE5 thresholds share 13-bit magnitude scale
    aftd_chan_detect u_det (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .sample_i(sample_arr[c]),
      .upper_i(upper_thr),
      .lower_i(lower_thr),
      .dwell_i(dwell),
      .threshold_flag_o(flag_arr[c])
    );

    // RULE10 sample and bit share one register
    // RULE11 control bit when enabled
    always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
        link_arr[c] <= '0;
      end else begin
        link_arr[c] <= {sample_arr[c], ctrl_en && ovr_arr[c], 1'b0};
      end
    end
  end

  assign threshold_flag_pin_ch0_o = flag_arr[0];
  assign threshold_flag_pin_ch1_o = flag_arr[1];
  assign link_sample_ch0_o = link_arr[0];
  assign link_sample_ch1_o = link_arr[1];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_upper_write;
    wr_stb && wr_addr == aftd_pkg::ADDR_UPPER_LO |=> upper_thr[aftd_pkg::DATA_W-1:0] == $past(wr_data);
  endproperty
  a_upper_write: assert property (p_upper_write) else $error("upper threshold write lost"); // RULE8

  property p_dwell_write;
    wr_stb && wr_addr == aftd_pkg::ADDR_DWELL_HI |=>
      dwell[aftd_pkg::DWELL_W-1:aftd_pkg::DATA_W] == $past(wr_data);
  endproperty
  a_dwell_write: assert property (p_dwell_write) else $error("dwell write lost"); // RULE9

  property p_ovr_align;
    1'b1 |=> link_sample_ch0_o[aftd_pkg::OVR_BIT] == ($past(overrange_ch0_i) && $past(ctrl_en)) &&
             link_sample_ch0_o[aftd_pkg::LINK_W-1:aftd_pkg::LINK_W-aftd_pkg::SAMPLE_W] == $past(sample_ch0_i);
  endproperty
  a_ovr_align: assert property (p_ovr_align) else $error("overrange bit not aligned with sample"); // RULE10

  sequence s_read_instr;
    instr_done && next_shreg[aftd_pkg::ADDR_W];
  endsequence

  property p_read_load;
    s_read_instr |=> reading && sdo_shift == $past(rd_data);
  endproperty
  a_read_load: assert property (p_read_load) else $error("read byte not loaded"); // RULE8

  property p_status_read;
    instr_done && next_shreg[aftd_pkg::ADDR_W] && rd_addr == aftd_pkg::ADDR_OVR_STATUS |=>
      sdo_shift == $past(ovr_status);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong"); // RULE12

  property p_sdo_shift;
    sclk_fall && !spi_cs_n_i && bit_cnt > aftd_pkg::CNT_INSTR |=>
      sdo_shift == ($past(sdo_shift) << 1'b1);
  endproperty
  a_sdo_shift: assert property (p_sdo_shift) else $error("read byte not shifted"); // RULE8

  property p_idle_port;
    spi_cs_n_i |=> spi_sdo_oe_n_o && bit_cnt == '0;
  endproperty
  a_idle_port: assert property (p_idle_port) else $error("port not idle when deselected"); // RULE8

  property p_frame_cap;
    bit_cnt <= aftd_pkg::CNT_FRAME;
  endproperty
  a_frame_cap: assert property (p_frame_cap) else $error("bit count past frame"); // RULE8

  property p_upper_hi_write;
    wr_stb && wr_addr == aftd_pkg::ADDR_UPPER_HI |=>
      upper_thr[aftd_pkg::MAG_W-1:aftd_pkg::DATA_W] == $past(wr_data[aftd_pkg::MAG_W-aftd_pkg::DATA_W-1:0]);
  endproperty
  a_upper_hi_write: assert property (p_upper_hi_write) else $error("upper high write lost"); // RULE8

  property p_lower_lo_write;
    wr_stb && wr_addr == aftd_pkg::ADDR_LOWER_LO |=> lower_thr[aftd_pkg::DATA_W-1:0] == $past(wr_data);
  endproperty
  a_lower_lo_write: assert property (p_lower_lo_write) else $error("lower low write lost"); // RULE9

  property p_lower_hi_write;
    wr_stb && wr_addr == aftd_pkg::ADDR_LOWER_HI |=>
      lower_thr[aftd_pkg::MAG_W-1:aftd_pkg::DATA_W] == $past(wr_data[aftd_pkg::MAG_W-aftd_pkg::DATA_W-1:0]);
  endproperty
  a_lower_hi_write: assert property (p_lower_hi_write) else $error("lower high write lost"); // RULE9

  property p_dwell_lo_write;
    wr_stb && wr_addr == aftd_pkg::ADDR_DWELL_LO |=> dwell[aftd_pkg::DATA_W-1:0] == $past(wr_data);
  endproperty
  a_dwell_lo_write: assert property (p_dwell_lo_write) else $error("dwell low write lost"); // RULE9

  sequence s_clear_write;
    wr_stb && wr_addr == aftd_pkg::ADDR_OVR_CLEAR;
  endsequence

  property p_clear_write;
    s_clear_write |=> ovr_clear == $past(wr_data);
  endproperty
  a_clear_write: assert property (p_clear_write) else $error("clear write lost"); // RULE13

  property p_upper_keep;
    !wr_stb |=> $stable(upper_thr);
  endproperty
  a_upper_keep: assert property (p_upper_keep) else $error("upper changed unwritten"); // RULE8

  property p_lower_keep;
    !wr_stb |=> $stable(lower_thr);
  endproperty
  a_lower_keep: assert property (p_lower_keep) else $error("lower changed unwritten"); // RULE9

  property p_dwell_keep;
    !wr_stb |=> $stable(dwell);
  endproperty
  a_dwell_keep: assert property (p_dwell_keep) else $error("dwell changed unwritten"); // RULE7

  property p_clear_keep;
    !wr_stb |=> $stable(ovr_clear);
  endproperty
  a_clear_keep: assert property (p_clear_keep) else $error("clear changed unwritten"); // RULE13

  property p_status_ro;
    vc_overrange_i == '0 |=> (ovr_status & ~$past(ovr_status)) == '0;
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status set without event"); // RULE12

  property p_ovr_align_ch1;
    1'b1 |=> link_sample_ch1_o[aftd_pkg::OVR_BIT] == ($past(overrange_ch1_i) && $past(ctrl_en)) &&
             link_sample_ch1_o[aftd_pkg::LINK_W-1:aftd_pkg::LINK_W-aftd_pkg::SAMPLE_W] == $past(sample_ch1_i);
  endproperty
  a_ovr_align_ch1: assert property (p_ovr_align_ch1) else $error("channel 1 link word misaligned"); // RULE10

  property p_ctrl_off;
    !ctrl_en |=> !link_sample_ch0_o[aftd_pkg::OVR_BIT] && !link_sample_ch1_o[aftd_pkg::OVR_BIT];
  endproperty
  a_ctrl_off: assert property (p_ctrl_off) else $error("control bit sent while disabled"); // RULE11
endmodule : aftd_top

// ===== sim/aftd_agc_model.sv
// gain control model that watches the two detect pins
`timescale 1ns/100ps
module aftd_agc_model (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic flag_ch0_i,
  input wire logic flag_ch1_i,
  output logic [7:0] gain_step_ch0_o,
  output logic [7:0] gain_step_ch1_o
);
  logic [1:0] flag_prev;
  ////////////////////////////////////////////////////////////////
  // one pin per channel
  // each rising flag asks for one gain cut on its own channel only
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      flag_prev <= 2'h0;
      gain_step_ch0_o <= 8'h00;
      gain_step_ch1_o <= 8'h00;
    end else begin
      flag_prev <= {flag_ch1_i, flag_ch0_i};
      if (flag_ch0_i && !flag_prev[0]) gain_step_ch0_o <= gain_step_ch0_o + 8'h01;
      if (flag_ch1_i && !flag_prev[1]) gain_step_ch1_o <= gain_step_ch1_o + 8'h01;
    end
  end
endmodule : aftd_agc_model

// ===== sim/aftd_top_tb_top.sv
// self-checking bench for the fast threshold detect block
`timescale 1ns/100ps
module aftd_top_tb_top;
  localparam int MAX_CYCLES = 20000;
  logic core_clk_i;
  logic reset_n_i;
  logic [13:0] sample_ch0;
  logic [13:0] sample_ch1;
  logic ovr_ch0;
  logic ovr_ch1;
  logic [7:0] vc_ovr;
  logic [1:0] cbps;
  logic spi_cs_n;
  logic spi_sclk;
  logic spi_sdi;
  logic spi_sdo;
  logic spi_sdo_oe_n;
  logic flag_ch0;
  logic flag_ch1;
  logic [15:0] link_ch0;
  logic [15:0] link_ch1;
  logic [7:0] gain_ch0;
  logic [7:0] gain_ch1;
  logic [7:0] rd;
  int bad_count;
  int tests_run;
  int cycles;

  aftd_top u_aftd_top (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .sample_ch0_i(sample_ch0),
    .sample_ch1_i(sample_ch1), .overrange_ch0_i(ovr_ch0), .overrange_ch1_i(ovr_ch1), .vc_overrange_i(vc_ovr),
    .control_bits_per_sample_i(cbps), .spi_cs_n_i(spi_cs_n), .spi_sclk_i(spi_sclk), .spi_sdi_i(spi_sdi),
    .spi_sdo_o(spi_sdo), .spi_sdo_oe_n_o(spi_sdo_oe_n), .threshold_flag_pin_ch0_o(flag_ch0),
    .threshold_flag_pin_ch1_o(flag_ch1), .link_sample_ch0_o(link_ch0), .link_sample_ch1_o(link_ch1));

  aftd_agc_model u_aftd_agc_model (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .flag_ch0_i(flag_ch0),
    .flag_ch1_i(flag_ch1), .gain_step_ch0_o(gain_ch0), .gain_step_ch1_o(gain_ch1));

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  ////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles >= MAX_CYCLES) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // inputs always change 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : step

  ////////////////////////////////////////////////////////////////
  // serial frame: r/w bit, 15 address bits, 8 data bits, msb first;
  // each sclk phase lasts two core clocks so every edge is seen
  task automatic spi_xfer(input logic rw, input logic [14:0] addr, input logic [7:0] wdata,
                          output logic [7:0] rdata);
    logic [23:0] word;
    word = {rw, addr, wdata};
    rdata = 8'h00;
    spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_sdi = word[i];
      step(2);
      if (i < 8) rdata[i] = spi_sdo;
      if (i == 0) check({15'h0, spi_sdo_oe_n}, {15'h0, !rw});
      spi_sclk = 1'b1;
      step(2);
      spi_sclk = 1'b0;
    end
    step(2);
    spi_cs_n = 1'b1;
    step(4);
  endtask : spi_xfer

  task automatic reg_wr(input logic [14:0] addr, input logic [7:0] data);
    logic [7:0] unused;
    spi_xfer(1'b0, addr, data, unused);
  endtask : reg_wr

  task automatic reg_chk(input logic [14:0] addr, input logic [7:0] exp);
    logic [7:0] data;
    spi_xfer(1'b1, addr, 8'h00, data);
    check({8'h00, data}, {8'h00, exp});
  endtask : reg_chk

  // hold a channel-0 sample for n edges
  task automatic hold0(input logic [13:0] s, input int n);
    sample_ch0 = s;
    step(n);
  endtask : hold0

  ////////////////////////////////////////////////////////////////
  initial begin
    bad_count = 0;
    tests_run = 0;
    cycles = 0;
    reset_n_i = 1'b0;
    sample_ch0 = 14'h0000;
    sample_ch1 = 14'h0000;
    ovr_ch0 = 1'b0;
    ovr_ch1 = 1'b0;
    vc_ovr = 8'h00;
    cbps = 2'h0;
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi = 1'b0;
    step(4);
    reset_n_i = 1'b1;
    step(1);
    check({14'h0, flag_ch1, flag_ch0}, 16'h0000);
    reg_chk(15'h0247, 8'hff);
    reg_chk(15'h0248, 8'h1f);
    reg_chk(15'h0249, 8'h00);
    reg_chk(15'h024b, 8'h01);
    reg_chk(15'h0563, 8'h00);
    reg_chk(15'h0250, 8'h00);
    // upper 0x1000, lower 0x0800, dwell 3; top bits of the high byte drop
    reg_wr(15'h0248, 8'hff);
    reg_chk(15'h0248, 8'h1f);
    reg_wr(15'h0247, 8'h00);
    reg_wr(15'h0248, 8'h10);
    reg_wr(15'h0249, 8'h00);
    reg_wr(15'h024a, 8'h08);
    reg_wr(15'h024b, 8'h03);
    reg_wr(15'h024c, 8'h00);
    reg_chk(15'h0248, 8'h10);
    reg_chk(15'h024a, 8'h08);
    reg_chk(15'h024c, 8'h00);
    // magnitude equal to upper does not exceed it, either sign
    hold0(14'h1000, 4);
    check({15'h0, flag_ch0}, 16'h0000);
    hold0(14'h3000, 4);
    check({15'h0, flag_ch0}, 16'h0000);
    hold0(14'h1001, 3);
    check({15'h0, flag_ch0}, 16'h0001);
    check({15'h0, flag_ch1}, 16'h0000);
    // dwell samples below, then one equal to lower restarts the count
    hold0(14'h0000, 3);
    hold0(14'h0800, 6);
    check({15'h0, flag_ch0}, 16'h0001);
    hold0(14'h0000, 3);
    hold0(14'h0800, 6);
    check({15'h0, flag_ch0}, 16'h0001);
    hold0(14'h0000, 4);
    hold0(14'h0800, 6);
    check({15'h0, flag_ch0}, 16'h0000);
    hold0(14'h2000, 3);
    check({15'h0, flag_ch0}, 16'h0001);
    hold0(14'h0000, 10);
    check({15'h0, flag_ch0}, 16'h0000);
    // channel 1 on its own, negative sample of magnitude 0x1500
    sample_ch1 = 14'h2b00;
    step(3);
    check({14'h0, flag_ch1, flag_ch0}, 16'h0002);
    // dwell 256 exercises the high byte
    reg_wr(15'h024b, 8'h00);
    reg_wr(15'h024c, 8'h01);
    sample_ch1 = 14'h0000;
    step(256);
    sample_ch1 = 14'h0800;
    step(6);
    check({15'h0, flag_ch1}, 16'h0001);
    sample_ch1 = 14'h0000;
    step(257);
    sample_ch1 = 14'h0800;
    step(6);
    check({15'h0, flag_ch1}, 16'h0000);
    check({8'h00, gain_ch1}, 16'h0001);
    // link word: sample, overrange bit when control bits enabled, zero
    for (int c = 0; c < 4; c++) begin
      cbps = c[1:0];
      sample_ch0 = 14'h1234;
      sample_ch1 = 14'h0abc;
      ovr_ch0 = 1'b1;
      ovr_ch1 = c[0];
      step(1);
      check(link_ch0, {14'h1234, (c != 0), 1'b0});
      check(link_ch1, {14'h0abc, (c[0] == 1'b1), 1'b0});
    end
    ovr_ch0 = 1'b0;
    ovr_ch1 = 1'b0;
    // sticky bits per virtual converter, cleared only by a high-low toggle
    for (int v = 0; v < 8; v++) begin
      vc_ovr = 8'h01 << v;
      step(1);
      vc_ovr = 8'h00;
      step(1);
      reg_chk(15'h0563, 8'h01 << v);
      reg_wr(15'h0562, 8'h01 << v);
      reg_chk(15'h0563, 8'h01 << v);
      reg_wr(15'h0562, 8'h00);
      reg_chk(15'h0563, 8'h00);
    end
    reg_wr(15'h0563, 8'hff);
    reg_chk(15'h0563, 8'h00);
    check({8'h00, gain_ch0}, 16'h0003);
    // reset in mid-run drops the flags and restores register defaults
    reset_n_i = 1'b0;
    step(2);
    reset_n_i = 1'b1;
    step(1);
    check({14'h0, flag_ch1, flag_ch0}, 16'h0000);
    reg_chk(15'h0247, 8'hff);
    reg_chk(15'h024b, 8'h01);
    stop_test();
  end
endmodule : aftd_top_tb_top
